/* rtl/client_event_pkg.sv */
// constants for the client-group event status block
// assumes a 32-bit axi4-lite register port and one system clock
package client_event_pkg;

  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] STATUS_OFFSET = 12'h120;
  localparam logic [11:0] MASK_OFFSET = 12'h124;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // bits that hold a client; 31..30 and 18 are reserved
  localparam logic [31:0] IMPL_BITS = 32'h3ffb_ffff;
  // clients whose default event is end-of-frame received
  localparam logic [31:0] CAPTURE_DIR_BITS = 32'h3c23_03fc;

  // -------------------------------------------------------------
  // client bit positions
  // -------------------------------------------------------------
  localparam int CAP2_ANCILLARY_B_EVENT = 29;
  localparam int CAP2_ANCILLARY_A_EVENT = 28;
  localparam int CAP1_ANCILLARY_B_EVENT = 27;
  localparam int CAP1_ANCILLARY_A_EVENT = 26;
  localparam int XFER2_LUMA_EVENT = 25;
  localparam int XFER2_CHROMA_EVENT = 24;
  localparam int XFER1_LUMA_EVENT = 23;
  localparam int XFER1_CHROMA_EVENT = 22;
  localparam int WRITEBACK_OUT_EVENT = 21;
  localparam int PORT_CTRL_EVENT = 20;
  localparam int VBLANK_ENC_EVENT = 19;
  localparam int DENOISE_CHROMA_OUT_EVENT = 17;
  localparam int GRAPHICS_PLANE_DATA_EVENT = 0;

  // -------------------------------------------------------------
  // event selection carried by a control descriptor
  // -------------------------------------------------------------
  localparam logic [1:0] EV_END_OF_FRAME = 2'h0;
  localparam logic [1:0] EV_START_OF_FRAME = 2'h1;
  localparam logic [1:0] EV_LINE_COUNT = 2'h2;
  localparam logic [1:0] EV_NONE = 2'h3;
  localparam logic [1:0] EV_RESET = 2'h0;

  // -------------------------------------------------------------
  // axi response codes
  // -------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : client_event_pkg

/* rtl/video_dma_client_event_status.sv */
// sticky client event status register with mask and interrupt
// assumes axi4-lite master on aclk, client strobes synchronous to aclk
//
// Overview of operation
// [RQ1] status register at 0x120, 32 bits, all zero after reset
// [RQ2] client bit sets when its descriptor-selected event occurs
// [RQ3] capture clients without descriptor set on end-of-frame received
// [RQ4] display clients without descriptor set on end-of-frame sent
// [RQ5] a set bit stays set until software clears it or reset
// [RQ6] writing one clears that bit only; zero bits are untouched
// [RQ7] bits 29..26: cap2 ancillary b, a, cap1 ancillary b, a
// [RQ8] bits 25..22: xfer2 luma, xfer2 chroma, xfer1 luma, xfer1 chroma
// [RQ9] bit 21 write-back out, 20 port control, 19 vblank encoder
// [RQ10] bits 31..30 and 18 read zero and ignore writes
// [RQ11] bits 17..13 denoise, 12..10 graphics stream, 9..2 capture, 1..0 graphics
// [RQ12] status sets regardless of mask; irq when set bit is unmasked
// [RQ13] event and clear on same bit in same cycle leave it set
`timescale 1ns/1ns
`default_nettype none

module video_dma_client_event_status (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // client strobes, one bit per status position
  input wire logic [31:0] eof_received,
  input wire logic [31:0] eof_sent,
  input wire logic [31:0] sof_strobe,
  input wire logic [31:0] line_strobe,
  // control descriptor delivery
  input wire logic desc_valid,
  input wire logic [4:0] desc_client,
  input wire logic [1:0] desc_event,
  // interrupt
  output logic irq
);

  // -------------------------------------------------------------
  // functions
  // -------------------------------------------------------------
  // byte strobes widened to a bit mask
  function automatic logic [31:0] strb_bits(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++)
    begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return m;
  endfunction : strb_bits

  // one client's event under its current selection
  function automatic logic client_hit(input logic [1:0] sel, input logic eof,
                                      input logic sof, input logic line);
    logic h;
    h = 1'b0;
    case (sel)
      client_event_pkg::EV_END_OF_FRAME: h = eof;
      client_event_pkg::EV_START_OF_FRAME: h = sof;
      client_event_pkg::EV_LINE_COUNT: h = line;
      default: h = 1'b0;
    endcase
    return h;
  endfunction : client_hit

  // word-aligned offset compare
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction : addr_is

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [31:0] mask_q;
  logic [1:0] sel_q [32];
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q;
  logic w_have_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic irq_q;
  logic do_write;
  logic [31:0] wmask;
  logic [31:0] clr_vec;
  logic [31:0] set_vec;
  logic [31:0] default_eof;
  logic [31:0] held_vec;
  logic [31:0] clear_only;
  logic pend;

  // -------------------------------------------------------------
  // event detection
  // -------------------------------------------------------------
  // default end-of-frame depends on the client's direction
  assign default_eof = (eof_received & client_event_pkg::CAPTURE_DIR_BITS) |
                       (eof_sent & ~client_event_pkg::CAPTURE_DIR_BITS); // RQ3 RQ4

  // per-client event, unmasked by the interrupt mask
  always_comb
  begin
    set_vec = 32'h0000_0000;
    for (int i = 0; i < 32; i++)
    begin
      set_vec[i] = client_hit(sel_q[i], default_eof[i], sof_strobe[i], line_strobe[i]); // RQ2
    end
    set_vec = set_vec & client_event_pkg::IMPL_BITS; // RQ7 RQ8 RQ9 RQ10 RQ11 RQ12
  end

  // descriptor selection per client, end-of-frame until configured
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 32; i++)
      begin
        sel_q[i] <= client_event_pkg::EV_RESET;
      end
    end
    else if (desc_valid)
    begin
      sel_q[desc_client] <= desc_event; // RQ2
    end
  end

  // -------------------------------------------------------------
  // status register
  // -------------------------------------------------------------
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign wmask = strb_bits(wstrb_q);
  assign clr_vec = (do_write && addr_is(awaddr_q, client_event_pkg::STATUS_OFFSET)) ?
                   (wdata_q & wmask) : 32'h0000_0000; // RQ6
  // set wins over clear; reserved bits forced low
  assign status_d = ((status_q & ~clr_vec) | set_vec) &
                    client_event_pkg::IMPL_BITS; // RQ5 RQ13 RQ10

  // sticky status flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_q <= client_event_pkg::STATUS_RESET; // RQ1
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // mask register, byte-lane writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_q <= client_event_pkg::MASK_RESET;
    end
    else if (do_write && addr_is(awaddr_q, client_event_pkg::MASK_OFFSET))
    begin
      mask_q <= ((mask_q & ~wmask) | (wdata_q & wmask)) & client_event_pkg::IMPL_BITS;
    end
  end

  // level interrupt from any unmasked set bit
  assign pend = |(status_q & mask_q);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= pend; // RQ12
    end
  end

  // -------------------------------------------------------------
  // axi4-lite write channel
  // -------------------------------------------------------------
  // address and data taken in either order, response after both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= client_event_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready_q)
      begin
        awaddr_q <= awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      else if (!aw_have_q && !bvalid_q)
      begin
        awready_q <= 1'b1;
      end
      if (wvalid && wready_q)
      begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      else if (!w_have_q && !bvalid_q)
      begin
        wready_q <= 1'b1;
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        if (addr_is(awaddr_q, client_event_pkg::STATUS_OFFSET) ||
            addr_is(awaddr_q, client_event_pkg::MASK_OFFSET))
        begin
          bresp_q <= client_event_pkg::RESP_OKAY;
        end
        else
        begin
          bresp_q <= client_event_pkg::RESP_SLVERR;
        end
      end
      else if (bvalid_q && bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // axi4-lite read channel
  // -------------------------------------------------------------
  // one read at a time, data held until rready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= client_event_pkg::RESP_OKAY;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      if (addr_is(araddr, client_event_pkg::STATUS_OFFSET))
      begin
        rdata_q <= status_q & client_event_pkg::IMPL_BITS; // RQ10
        rresp_q <= client_event_pkg::RESP_OKAY;
      end
      else if (addr_is(araddr, client_event_pkg::MASK_OFFSET))
      begin
        rdata_q <= mask_q;
        rresp_q <= client_event_pkg::RESP_OKAY;
      end
      else
      begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= client_event_pkg::RESP_SLVERR;
      end
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q <= 1'b0;
    end
    else if (!rvalid_q)
    begin
      arready_q <= 1'b1;
    end
  end

  // outputs straight from flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq = irq_q;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  assign held_vec = status_q & ~clr_vec;
  assign clear_only = status_q & clr_vec & ~set_vec;
  a_reset_clear: assert property (@(posedge aclk) !aresetn |=> status_q == 32'h0) // RQ1
    else $error("status not zero after reset");
  a_event_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (set_vec != 32'h0) |=> ((status_q & $past(set_vec)) == $past(set_vec))) // RQ2
    else $error("client event did not set its bit");
  a_cap_default: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_q[29] == 2'h0 && eof_received[29]) |=> status_q[29]) // RQ3
    else $error("capture default end-of-frame lost");
  a_disp_default: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_q[25] == 2'h0 && eof_sent[25] && !eof_received[25]) |=> status_q[25]) // RQ4
    else $error("display default end-of-frame lost");
  a_bit_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (held_vec != 32'h0) |=> ((status_q & $past(held_vec)) == $past(held_vec))) // RQ5
    else $error("status bit dropped without clear");
  a_w1c_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (clear_only != 32'h0) |=> ((status_q & $past(clear_only)) == 32'h0)) // RQ6
    else $error("write one did not clear bit");
  a_map_cap1: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_q[26] == 2'h1 && sof_strobe[26]) |=> status_q[26]) // RQ7
    else $error("cap1 ancillary a not on bit 26");
  a_map_xfer: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_q[22] == 2'h2 && line_strobe[22]) |=> status_q[22]) // RQ8
    else $error("xfer1 chroma not on bit 22");
  a_map_vblank: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_q[19] == 2'h0 && eof_sent[19] && !eof_received[19]) |=> status_q[19]) // RQ9
    else $error("vblank client not on bit 19");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q |-> (rdata_q[31:30] == 2'h0 && rdata_q[18] == 1'b0)) // RQ10
    else $error("reserved bits read nonzero");
  a_map_denoise: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_q[13] == 2'h0 && eof_sent[13] && !eof_received[13]) |=> status_q[13]) // RQ11
    else $error("denoise input not on bit 13");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_q == $past(pend)) // RQ12
    else $error("irq not following unmasked status");
  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    ((set_vec & clr_vec) != 32'h0) |=> ((status_q & $past(set_vec)) == $past(set_vec))) // RQ13
    else $error("event lost against clear");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid_q && !bready) |=> bvalid_q)
    else $error("write response withdrawn");
endmodule : video_dma_client_event_status
`default_nettype wire

/* test/client_model.sv */
// far-side client model: drives one event strobe on command
// assumes go is a one-cycle request set just after a rising edge
`timescale 1ns/1ns
`default_nettype none

module client_model (
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic [4:0] idx,
  output logic [31:0] eof_received,
  output logic [31:0] eof_sent,
  output logic [31:0] sof_strobe,
  output logic [31:0] line_strobe
);
  // ------------------------------
  // strobes
  // ------------------------------
  logic [31:0] one;

  // all strobes low outside a request, so no stale pulse lingers
  always_comb
  begin
    one = 32'h1 << idx;
    eof_received = (go && kind == 2'h0) ? one : 32'h0;
    eof_sent = (go && kind == 2'h1) ? one : 32'h0;
    sof_strobe = (go && kind == 2'h2) ? one : 32'h0;
    line_strobe = (go && kind == 2'h3) ? one : 32'h0;
  end
endmodule : client_model
`default_nettype wire

/* test/tb_video_dma_client_event_status.sv */
// self-checking bench for the client event status block
// assumes the client model drives the strobes, bench is the axi master
`timescale 1ns/1ns
`default_nettype none

module tb_video_dma_client_event_status;
  // ------------------------------
  // signals
  // ------------------------------
  localparam int LIMIT = 20000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0, wst;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, eof_received, eof_sent, sof_strobe, line_strobe;
  logic desc_valid = 1'b0, go = 1'b0, coll = 1'b0;
  logic [4:0] desc_client = 5'h0, idx = 5'h0;
  logic [1:0] desc_event = 2'h0, kind = 2'h0;
  logic [1:0] sel [32];
  logic [31:0] exp_st, exp_mk, rd_v, rnd;
  int failures = 0, comparisons = 0, cyc = 0, cl;
  integer seed = 7502;

  always #50 aclk = ~aclk;

  video_dma_client_event_status u_video_dma_client_event_status (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .eof_received, .eof_sent, .sof_strobe, .line_strobe, .desc_valid,
    .desc_client, .desc_event, .irq
  );

  client_model u_client_model (
    .go, .kind, .idx, .eof_received, .eof_sent, .sof_strobe, .line_strobe
  );

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // write; coll fires the queued event in the cycle the clear is applied
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got)
    begin
      @(posedge aclk);
      // both halves taken at this edge: the clear is applied at the next one
      go <= coll && awvalid && awready && wvalid && wready;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        got = 1'b1;
        resp = bresp;
      end
    end
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        got = 1'b1;
        rd_v = rdata;
        resp = rresp;
      end
    end
    rready <= 1'b0;
  endtask : axi_rd

  task automatic chk_st();
    axi_rd(client_event_pkg::STATUS_OFFSET);
    chk("status", exp_st, rd_v);
    chk("irq", {31'h0, |(exp_st & exp_mk)}, {31'h0, irq});
  endtask : chk_st

  // whether strobe kind k on client i must set its bit
  function automatic logic hit(input logic [4:0] i, input logic [1:0] k);
    logic cap;
    cap = (i >= 5'h1a && i <= 5'h1d) || i == 5'h15 || i == 5'h11 || i == 5'h10
      || (i >= 5'h2 && i <= 5'h9);
    if (i == 5'h1f || i == 5'h1e || i == 5'h12)
      return 1'b0;
    case (sel[i])
      2'h0: return k == (cap ? 2'h0 : 2'h1);
      2'h1: return k == 2'h2;
      2'h2: return k == 2'h3;
      default: return 1'b0;
    endcase
  endfunction : hit

  task automatic fire(input logic [1:0] k, input logic [4:0] i);
    @(posedge aclk);
    go <= 1'b1;
    kind <= k;
    idx <= i;
    @(posedge aclk);
    go <= 1'b0;
    if (hit(i, k))
      exp_st[i] = 1'b1;
  endtask : fire

  task automatic set_desc(input logic [4:0] c, input logic [1:0] e);
    @(posedge aclk);
    desc_valid <= 1'b1;
    desc_client <= c;
    desc_event <= e;
    sel[c] = e;
    @(posedge aclk);
    desc_valid <= 1'b0;
  endtask : set_desc

  // ------------------------------
  // hang guard
  // ------------------------------
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      failures++;
      test_done();
    end
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    for (int i = 0; i < 32; i++)
      sel[i] = 2'h0;
    exp_st = 32'h0;
    exp_mk = 32'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk_st();
    axi_rd(client_event_pkg::MASK_OFFSET);
    chk("mask", 32'h0, rd_v);
    axi_rd(12'h200);
    chk("rresp", 32'h2, {30'h0, resp});
    axi_wr(12'h200, 32'hffff_ffff, 4'hf);
    chk("bresp", 32'h2, {30'h0, resp});
    axi_wr(client_event_pkg::MASK_OFFSET, 32'hffff_ffff, 4'hf);
    exp_mk = 32'h3ffb_ffff;
    axi_rd(client_event_pkg::MASK_OFFSET);
    chk("mask", exp_mk, rd_v);
    // each client: opposite end-of-frame first, then its default one
    for (int i = 0; i < 32; i++)
    begin
      wst = hit(5'(i), 2'h0) ? 4'h1 : 4'h0;
      fire(wst[1:0], 5'(i));
      chk_st();
      fire(~wst[1:0] & 2'h1, 5'(i));
      chk_st();
    end
    axi_wr(client_event_pkg::STATUS_OFFSET, 32'hffff_ffff, 4'hf);
    exp_st = 32'h0;
    chk_st();
    // every descriptor selection, ending back at the default
    // a random low client, then clients 26 and 22 that the start-of-frame and line-count mapping checks watch
    for (int n = 0; n < 3; n++)
    begin
      cl = (n == 0) ? $unsigned($random(seed)) % 18 : (n == 1) ? 26 : 22;
      for (int e = 3; e >= 0; e--)
      begin
        set_desc(5'(cl), 2'(e));
        for (int k = 0; k < 4; k++)
        begin
          fire(2'(k), 5'(cl));
          chk_st();
        end
        axi_wr(client_event_pkg::STATUS_OFFSET, 32'h1 << cl, 4'hf);
        exp_st[cl] = 1'b0;
      end
    end
    // event and clear on the same bit in the same cycle
    fire(2'h0, 5'h1d);
    kind <= 2'h0;
    idx <= 5'h1d;
    coll = 1'b1;
    axi_wr(client_event_pkg::STATUS_OFFSET, 32'h2000_0000, 4'hf);
    coll = 1'b0;
    chk_st();
    // random events and partial-lane clears
    repeat (40)
    begin
      fire(2'($random(seed)), 5'($random(seed)));
      rnd = $random(seed);
      wst = 4'($random(seed));
      axi_wr(client_event_pkg::STATUS_OFFSET, rnd, wst);
      for (int b = 0; b < 4; b++)
        if (wst[b])
          exp_st[8*b +: 8] = exp_st[8*b +: 8] & ~rnd[8*b +: 8];
      chk_st();
    end
    // reset in mid-run clears status, mask and irq
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    exp_st = 32'h0;
    exp_mk = 32'h0;
    chk_st();
    axi_rd(client_event_pkg::MASK_OFFSET);
    chk("mask", 32'h0, rd_v);
    // status still sets with everything masked, irq stays low
    axi_wr(client_event_pkg::MASK_OFFSET, 32'h0, 4'hf);
    exp_mk = 32'h0;
    fire(2'h1, 5'h19);
    chk_st();
    test_done();
  end
endmodule : tb_video_dma_client_event_status
`default_nettype wire
